//--- rtl/exec_cfg.svh
// constants for the subtract, rotate and sleep execution block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define EXEC_DATA_W 8
`define EXEC_ADDR_W 7
`define EXEC_ADDR_MAX 7'h7F
`define EXEC_WDOG_W 8
`define EXEC_PRESC_W 8
`define EXEC_ACC_RST 8'h00
`define EXEC_WDOG_ZERO 8'h00
`define EXEC_PRESC_ZERO 8'h00
`define EXEC_DEST_ACC 1'b0
`define EXEC_DEST_REG 1'b1
// timeout and powerdown set, arithmetic flags clear
`define EXEC_STAT_RST 5'h03
`define EXEC_WDATA_RST 8'h00
`define EXEC_WADDR_RST 7'h00
`define EXEC_PRESC_WRAP 8'hFF
`define EXEC_PRESC_STEP 8'h01
`define EXEC_WDOG_STEP 8'h01
`endif

//--- rtl/exec_pkg.sv
// types for the subtract, rotate and sleep execution block
package exec_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROTATE_RIGHT_CARRY = 3'h1,
    OP_SUB_REG_MINUS_ACC = 3'h2,
    OP_SUB_REG_MINUS_ACC_BORROW = 3'h3,
    OP_SUB_LITERAL_MINUS_ACC = 3'h4,
    OP_SLEEP = 3'h5
  } op_type;

  typedef struct packed {
    op_type op;
    logic [6:0] addr;
    logic dest;
    logic [7:0] literal;
  } instr_type;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } status_type;

  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic digit_carry;
    logic zero;
    logic flags_upd;
    logic carry_only;
  } alu_out_type;
endpackage

//--- rtl/sub_alu.sv
// combinational subtract and rotate unit
`timescale 1ns/10ps
`include "exec_cfg.svh"
module sub_alu
  import exec_pkg::*;
(
  input wire op_type op_i,        // operation
  input wire logic [7:0] reg_i,   // file register value
  input wire logic [7:0] acc_i,   // accumulator value
  input wire logic [7:0] lit_i,   // literal
  input wire logic carry_i,       // current carry
  output alu_out_type out_o       // result and flags
);
  logic [7:0] minuend;
  logic bin;
  logic [8:0] diff;
  logic [4:0] ldiff;

  always_comb begin
    minuend = (op_i == OP_SUB_LITERAL_MINUS_ACC) ? lit_i : reg_i;
    bin = (op_i == OP_SUB_REG_MINUS_ACC_BORROW) ? ~carry_i : 1'b0;
    // borrow out in bit 8, carry is its inverse
    diff = {1'b0, minuend} - {1'b0, acc_i} - {8'h00, bin};
    ldiff = {1'b0, minuend[3:0]} - {1'b0, acc_i[3:0]} - {4'h0, bin};
    out_o = '0;
    unique case (op_i)
      OP_ROTATE_RIGHT_CARRY: begin
        out_o.result = {carry_i, reg_i[7:1]};
        out_o.carry = reg_i[0];
        out_o.carry_only = 1'b1;
      end
      OP_SUB_REG_MINUS_ACC, OP_SUB_REG_MINUS_ACC_BORROW, OP_SUB_LITERAL_MINUS_ACC: begin
        out_o.result = diff[7:0];
        out_o.carry = ~diff[8];
        out_o.digit_carry = ~ldiff[4];
        out_o.zero = (diff[7:0] == 8'h00);
        out_o.flags_upd = 1'b1;
      end
      default: begin
        out_o = '0;
      end
    endcase
  end
endmodule

//--- rtl/subtract_rotate_sleep_exec.sv
// execution unit for rotate right, three subtractions and sleep entry
`timescale 1ns/10ps
`include "exec_cfg.svh"
module subtract_rotate_sleep_exec
  import exec_pkg::*;
(
  input wire logic clk_i,              // 50 mhz core clock
  input wire logic rst_i,              // sync reset, active high
  input wire logic instr_valid_i,      // instruction executes this cycle
  input wire instr_type instr_i,       // decoded instruction
  input wire logic [7:0] reg_rdata_i,  // file register read data at addr
  input wire logic wdog_tick_i,        // watchdog prescaler count enable
  output logic [6:0] reg_addr_o,       // file register address
  output logic reg_we_o,               // file register write strobe
  output logic [7:0] reg_wdata_o,      // file register write data
  output logic [7:0] acc_o,            // accumulator
  output status_type status_o,         // status flags
  output logic [7:0] watchdog_counter_o, // watchdog count
  output logic sleep_o                 // pulse on sleep entry
);
  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  alu_out_type alu;
  logic alu_op;
  logic sleep_op;
  logic to_acc;
  logic presc_wrap;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  status_type stat_r;
  status_type stat_nxt;
  logic [7:0] wd_r;
  logic [7:0] wd_nxt;
  logic [7:0] presc_r;
  logic [7:0] presc_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic we_r;
  logic we_nxt;
  logic [6:0] waddr_r;
  logic [6:0] waddr_nxt;

  sub_alu u_alu (
    .op_i(instr_i.op),
    .reg_i(reg_rdata_i),
    .acc_i(acc_r),
    .lit_i(instr_i.literal),
    .carry_i(stat_r.carry),
    .out_o(alu)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  always_comb begin
    alu_op = instr_valid_i && (alu.flags_upd || alu.carry_only);
    sleep_op = instr_valid_i && (instr_i.op == OP_SLEEP);
    // literal subtraction ignores the destination bit
    to_acc = (instr_i.op == OP_SUB_LITERAL_MINUS_ACC) || (instr_i.dest == `EXEC_DEST_ACC);
    presc_wrap = wdog_tick_i && (presc_r == `EXEC_PRESC_WRAP);
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt = acc_r;
    if (alu_op && to_acc) begin
      acc_nxt = alu.result;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= `EXEC_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb begin
    stat_nxt = stat_r;
    if (alu_op) begin
      stat_nxt.carry = alu.carry;
      // rotate leaves digit carry and zero alone
      if (alu.flags_upd) begin
        stat_nxt.digit_carry = alu.digit_carry;
        stat_nxt.zero = alu.zero;
      end
    end
    if (sleep_op) begin
      stat_nxt.powerdown_flag = 1'b0;
      stat_nxt.timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= `EXEC_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // watchdog prescaler
  // ----------------------------------------------------------------
  always_comb begin
    presc_nxt = presc_r;
    // sleep clear wins over a tick in the same cycle
    if (sleep_op) begin
      presc_nxt = `EXEC_PRESC_ZERO;
    end else if (wdog_tick_i) begin
      presc_nxt = presc_r + `EXEC_PRESC_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= `EXEC_PRESC_ZERO;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_comb begin
    wd_nxt = wd_r;
    if (sleep_op) begin
      wd_nxt = `EXEC_WDOG_ZERO;
    end else if (presc_wrap) begin
      wd_nxt = wd_r + `EXEC_WDOG_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_r <= `EXEC_WDOG_ZERO;
    end else begin
      wd_r <= wd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // writeback strobe
  // ----------------------------------------------------------------
  always_comb begin
    // one-cycle pulse, the address port follows it
    we_nxt = alu_op && !to_acc;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      we_r <= 1'b0;
    end else begin
      we_r <= we_nxt;
    end
  end

  // ----------------------------------------------------------------
  // writeback data and address
  // ----------------------------------------------------------------
  always_comb begin
    wdata_nxt = wdata_r;
    waddr_nxt = waddr_r;
    if (alu_op && !to_acc) begin
      wdata_nxt = alu.result;
      waddr_nxt = instr_i.addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata_r <= `EXEC_WDATA_RST;
      waddr_r <= `EXEC_WADDR_RST;
    end else begin
      wdata_r <= wdata_nxt;
      waddr_r <= waddr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // sleep entry pulse
  // ----------------------------------------------------------------
  always_comb begin
    sleep_nxt = sleep_op;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // while a writeback is pending the address port shows its target
  assign reg_addr_o = we_r ? waddr_r : instr_i.addr;
  assign reg_we_o = we_r;
  assign reg_wdata_o = wdata_r;
  assign acc_o = acc_r;
  assign status_o = stat_r;
  assign watchdog_counter_o = wd_r;
  assign sleep_o = sleep_r;
endmodule

//--- sim/exec_monitor.sv
// assertion checker on the execution block ports
`timescale 1ns/10ps
module exec_monitor
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire instr_type instr_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [6:0] reg_addr_o,
  input wire logic reg_we_o,
  input wire logic [7:0] acc_o,
  input wire status_type status_o,
  input wire logic [7:0] watchdog_counter_o,
  input wire logic sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ex(op_type o);
    instr_valid_i && instr_i.op == o;
  endsequence
  rot_carry_a: assert property (ex(OP_ROTATE_RIGHT_CARRY) |=>
    status_o.carry == $past(reg_rdata_i[0])) else $error("rot carry");
  dest_reg_a: assert property (ex(OP_SUB_REG_MINUS_ACC) ##0 instr_i.dest |=>
    reg_we_o && reg_addr_o == $past(instr_i.addr)) else $error("writeback");
  sleep_flags_a: assert property (ex(OP_SLEEP) |=>
    !status_o.powerdown_flag && status_o.timeout_flag) else $error("sleep flags");
  sleep_wdog_a: assert property (ex(OP_SLEEP) |=>
    watchdog_counter_o == 8'h00 && sleep_o) else $error("watchdog");
  sub_acc_a: assert property (ex(OP_SUB_REG_MINUS_ACC) ##0 !instr_i.dest |=>
    acc_o == $past(reg_rdata_i) - $past(acc_o)) else $error("sub");
  subb_acc_a: assert property (ex(OP_SUB_REG_MINUS_ACC_BORROW) ##0 !instr_i.dest |=>
    acc_o == $past(reg_rdata_i) - $past(acc_o) - !$past(status_o.carry)) else $error("subb");
  sublit_acc_a: assert property (ex(OP_SUB_LITERAL_MINUS_ACC) |=>
    acc_o == $past(instr_i.literal) - $past(acc_o) && !reg_we_o) else $error("sublit");
  sub_flags_a: assert property (ex(OP_SUB_LITERAL_MINUS_ACC) |=>
    status_o.carry == ($past(acc_o) <= $past(instr_i.literal)) && status_o.zero == (acc_o == 8'h00))
    else $error("flags");
endmodule
bind subtract_rotate_sleep_exec exec_monitor u_exec_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .reg_rdata_i(reg_rdata_i), .reg_addr_o(reg_addr_o),
  .reg_we_o(reg_we_o), .acc_o(acc_o), .status_o(status_o), .watchdog_counter_o(watchdog_counter_o),
  .sleep_o(sleep_o));

//--- sim/subtract_rotate_sleep_exec_test.sv
// random self-checking bench for the execution block
`timescale 1ns/10ps
module subtract_rotate_sleep_exec_test;
  import exec_pkg::*;
  logic clk_i, rst_i, instr_valid_i, wdog_tick_i, reg_we_o, sleep_o, c, dc, z, to, pd, n, u;
  logic [15:0] wcnt;
  logic [7:0] reg_rdata_i, reg_wdata_o, acc_o, watchdog_counter_o, a, r, res;
  logic [6:0] reg_addr_o;
  instr_type instr_i;
  status_type status_o;
  int num_errors, samples_checked;
  subtract_rotate_sleep_exec u_subtract_rotate_sleep_exec (.clk_i(clk_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .reg_rdata_i(reg_rdata_i), .wdog_tick_i(wdog_tick_i),
    .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o), .reg_wdata_o(reg_wdata_o), .acc_o(acc_o),
    .status_o(status_o), .watchdog_counter_o(watchdog_counter_o), .sleep_o(sleep_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // returns no-borrow, nibble no-borrow, difference
  function automatic logic [9:0] sub_f(input logic [7:0] m, s, input logic b);
    int unsigned w;
    int unsigned lo;
    // no borrow while the whole subtrahend does not exceed the minuend
    w = s + b;
    lo = s[3:0] + b;
    return {w <= m, lo <= m[3:0], 8'(m - s - b)};
  endfunction
  task chk(input string nm, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    reg_rdata_i = 8'h00;
    wdog_tick_i = 1'b0;
    void'($urandom(5106));
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    a = 8'h00;
    wcnt = 16'h0000;
    {c, dc, z, to, pd} = 5'h03;
    for (int i = 0; i < 300; i++) begin
      // first five: every op once, zero operands, top address; later op 0 too, which must do nothing
      instr_i.op = op_type'(i < 5 ? i + 1 : $urandom_range(0, 5));
      instr_i.addr = i < 5 ? 7'h7F : 7'($urandom);
      instr_i.dest = 1'($urandom);
      instr_i.literal = i < 5 ? 8'h00 : 8'($urandom);
      r = i < 5 ? 8'h00 : 8'($urandom);
      reg_rdata_i = r;
      wdog_tick_i = 1'($urandom);
      instr_valid_i = 1'b1;
      u = instr_i.op inside {[OP_ROTATE_RIGHT_CARRY:OP_SUB_LITERAL_MINUS_ACC]};
      n = u && instr_i.dest && instr_i.op != OP_SUB_LITERAL_MINUS_ACC;
      case (instr_i.op)
        OP_ROTATE_RIGHT_CARRY: {res, c} = {c, r};
        OP_SUB_REG_MINUS_ACC: {c, dc, res} = sub_f(r, a, 1'b0);
        OP_SUB_REG_MINUS_ACC_BORROW: {c, dc, res} = sub_f(r, a, ~c);
        OP_SUB_LITERAL_MINUS_ACC: {c, dc, res} = sub_f(instr_i.literal, a, 1'b0);
        OP_SLEEP: {to, pd} = 2'b10;
        default: res = 8'h00;
      endcase
      if (u && instr_i.op != OP_ROTATE_RIGHT_CARRY) z = res == 8'h00;
      if (u && !n) a = res;
      if (instr_i.op == OP_SLEEP) wcnt = 16'h0000;
      else if (wdog_tick_i) wcnt++;
      #1 chk("read addr", {1'b0, instr_i.addr}, {1'b0, reg_addr_o});
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      chk("acc", a, acc_o);
      chk("status", {3'h0, c, dc, z, to, pd}, {3'h0, status_o});
      chk("strobes", {6'h0, n, instr_i.op == OP_SLEEP}, {6'h0, reg_we_o, sleep_o});
      if (n) chk("wdata", res, reg_wdata_o);
      if (n) chk("addr", {1'b0, instr_i.addr}, {1'b0, reg_addr_o});
      if (instr_i.op == OP_SLEEP) chk("wdog", 8'h00, watchdog_counter_o);
      chk("wdog count", wcnt[15:8], watchdog_counter_o);
      if (wdog_tick_i) wcnt++;
      @(negedge clk_i);
    end
    // long tick run so the prescaler wraps into the watchdog count
    wdog_tick_i = 1'b1;
    repeat (600) begin
      @(negedge clk_i);
      wcnt++;
    end
    chk("wdog wrap", wcnt[15:8], watchdog_counter_o);
    tally_and_finish();
  end
endmodule
